// ==== core/clpm_pkg.sv ====
// Package with message class, opcode and cache state encodings for the packet matcher.
package clpm_pkg;

    // ========================================================================
    // Field widths
    // ========================================================================
    localparam int CLASS_W = 4;
    localparam int OPC_W   = 4;
    localparam int STATE_W = 3;

    // ========================================================================
    // Message classes
    // ========================================================================
    localparam logic [3:0] MC_HOME_REQ   = 4'h0;
    localparam logic [3:0] MC_HOME_RSP   = 4'h1;
    localparam logic [3:0] MC_NONDATA    = 4'h2;
    localparam logic [3:0] MC_SNOOP      = 4'h3;
    localparam logic [3:0] MC_NC_STD     = 4'h4;
    localparam logic [3:0] MC_NC_BYPASS  = 4'hc;
    localparam logic [3:0] MC_DATA_RSP   = 4'he;

    // ========================================================================
    // Cache state select codes carried by coherent data responses
    // ========================================================================
    localparam logic [2:0] CS_STATE_F = 3'h0;
    localparam logic [2:0] CS_STATE_E = 3'h1;
    localparam logic [2:0] CS_STATE_I = 3'h2;
    localparam logic [2:0] CS_STATE_M = 3'h3;
    localparam logic [2:0] CS_STATE_S = 3'h4;

    // ========================================================================
    // Data response opcodes that carry a cache state
    // ========================================================================
    localparam logic [3:0] OP_DATA_COHERENT = 4'h0;
    localparam logic [3:0] OP_DATA_FRC_ACK  = 4'h1;
    localparam logic [3:0] OP_DATA_CMP      = 4'h2;

    // ========================================================================
    // Opcodes by message class
    // ========================================================================
    localparam logic [3:0] OP_RQ_READ_CURRENT    = 4'h0;
    localparam logic [3:0] OP_RQ_READ_CODE       = 4'h1;
    localparam logic [3:0] OP_RQ_READ_DATA       = 4'h2;
    localparam logic [3:0] OP_RQ_READ_INV_OWN    = 4'h4;
    localparam logic [3:0] OP_RQ_INV_TO_EXCL     = 4'h8;
    localparam logic [3:0] OP_RQ_ACK_WITH_WB     = 4'h9;
    localparam logic [3:0] OP_RQ_WB_TO_INVALID   = 4'hc;
    localparam logic [3:0] OP_RQ_WB_TO_EXCL      = 4'hd;
    localparam logic [3:0] OP_RQ_WB_TO_SHARED    = 4'he;
    localparam logic [3:0] OP_RQ_CONFLICT_ACK    = 4'hf;

    localparam logic [3:0] OP_RS_PEER_INVALID    = 4'h0;
    localparam logic [3:0] OP_RS_PEER_SHARED     = 4'h1;
    localparam logic [3:0] OP_RS_PEER_CONFLICT   = 4'h4;
    localparam logic [3:0] OP_RS_FWD_UNCHANGED   = 4'h8;
    localparam logic [3:0] OP_RS_FWD_INVALID     = 4'h9;
    localparam logic [3:0] OP_RS_FWD_SHARED      = 4'ha;
    localparam logic [3:0] OP_RS_FWD_INVALID_WB  = 4'hb;
    localparam logic [3:0] OP_RS_FWD_SHARED_WB   = 4'hc;
    localparam logic [3:0] OP_RS_PEER_INVALID_WB = 4'hd;
    localparam logic [3:0] OP_RS_PEER_SHARED_WB  = 4'he;

    localparam logic [3:0] OP_ND_GRANT_EXCL      = 4'h0;
    localparam logic [3:0] OP_ND_GRANT_FORCE_ACK = 4'h1;
    localparam logic [3:0] OP_ND_CMP_WITH_DATA   = 4'h4;
    localparam logic [3:0] OP_ND_CMP_PLAIN       = 4'h8;
    localparam logic [3:0] OP_ND_CMP_FWD_CODE    = 4'ha;
    localparam logic [3:0] OP_ND_CMP_FWD_INV_OWN = 4'hb;
    localparam logic [3:0] OP_ND_CMP_INV_TO_EXCL = 4'hc;

    localparam logic [3:0] OP_SN_CURRENT         = 4'h0;
    localparam logic [3:0] OP_SN_CODE            = 4'h1;
    localparam logic [3:0] OP_SN_DATA            = 4'h2;
    localparam logic [3:0] OP_SN_INV_OWN         = 4'h4;
    localparam logic [3:0] OP_SN_INV_TO_EXCL     = 4'h8;
    localparam logic [3:0] OP_SN_PREFETCH_HINT   = 4'hf;

    localparam logic [3:0] OP_NS_MMIO_READ       = 4'h0;
    localparam logic [3:0] OP_NS_INT_ACK         = 4'h1;
    localparam logic [3:0] OP_NS_FLOAT_ERROR     = 4'h3;
    localparam logic [3:0] OP_NS_MMIO_PART_READ  = 4'h4;
    localparam logic [3:0] OP_NS_CFG_READ        = 4'h5;
    localparam logic [3:0] OP_NS_IO_READ         = 4'h7;
    localparam logic [3:0] OP_NS_CFG_WRITE       = 4'h9;
    localparam logic [3:0] OP_NS_IO_WRITE        = 4'hb;
    localparam logic [3:0] OP_NS_MESSAGE         = 4'hc;

    localparam logic [3:0] OP_NB_MMIO_WRITE      = 4'h0;
    localparam logic [3:0] OP_NB_WC_WRITE        = 4'h1;
    localparam logic [3:0] OP_NB_MESSAGE         = 4'h8;
    localparam logic [3:0] OP_NB_INT_LOGICAL     = 4'h9;
    localparam logic [3:0] OP_NB_INT_PHYSICAL    = 4'ha;
    localparam logic [3:0] OP_NB_INT_PRIO_UPDATE = 4'hb;
    localparam logic [3:0] OP_NB_MMIO_PART_WRITE = 4'hc;
    localparam logic [3:0] OP_NB_WC_PART_WRITE   = 4'hd;
    localparam logic [3:0] OP_NB_PEER_TRANSFER   = 4'he;

    localparam logic [3:0] OP_DR_NONCOHERENT     = 4'h3;
    localparam logic [3:0] OP_DR_WB_TO_INVALID   = 4'h4;
    localparam logic [3:0] OP_DR_WB_TO_SHARED    = 4'h5;
    localparam logic [3:0] OP_DR_WB_TO_EXCL      = 4'h6;
    localparam logic [3:0] OP_DR_UNCACHED_WRITE  = 4'h7;
    localparam logic [3:0] OP_DR_PART_WB_INVALID = 4'h8;
    localparam logic [3:0] OP_DR_PART_WB_EXCL    = 4'ha;
    localparam logic [3:0] OP_DR_PART_UNCACHED   = 4'hb;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic RST_MATCH = 1'b0;

endpackage

// ==== core/clpm_matcher.sv ====
// Packet class and opcode matcher feeding a monitoring counter.
`timescale 1ns/1ps

module clpm_matcher (
    // Clock, reset and enable
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST,
    input  wire logic                          CLK_EN,
    // Observed packet header
    input  wire logic                          HDR_VALID,
    input  wire logic [clpm_pkg::CLASS_W-1:0]  HDR_CLASS,
    input  wire logic [clpm_pkg::OPC_W-1:0]    HDR_OPCODE,
    input  wire logic [clpm_pkg::STATE_W-1:0]  HDR_CACHE_STATE,
    // Programmed match values from counter control state
    input  wire logic                          MATCH_ENABLE,
    input  wire logic [clpm_pkg::CLASS_W-1:0]  MATCH_CLASS,
    input  wire logic [clpm_pkg::OPC_W-1:0]    MATCH_OPCODE,
    input  wire logic [clpm_pkg::STATE_W-1:0]  CACHE_STATE_SELECT,
    // Counter side
    output logic                               MATCH_PULSE,
    output logic                               HDR_ASSIGNED
);
    import clpm_pkg::*;

    // ========================================================================
    // Transaction kinds
    // ========================================================================
    // Every class and opcode pair that this device produces has a kind of its
    // own. Encodings that exist on the link but are never produced here get
    // no kind, so a counter programmed with one of them simply counts nothing.
    typedef enum {
        K_NONE,

        // Home requests.
        K_READ_CURRENT_SNAPSHOT,
        K_READ_CODE_LINE,
        K_READ_DATA_LINE,
        K_READ_INVALIDATE_OWN,
        K_INVALIDATE_TO_EXCLUSIVE,
        K_CONFLICT_ACK_WITH_WRITEBACK,
        K_MODIFIED_WRITEBACK_TO_INVALID,
        K_MODIFIED_WRITEBACK_TO_EXCLUSIVE,
        K_MODIFIED_WRITEBACK_TO_SHARED,
        K_CONFLICT_ACKNOWLEDGE,

        // Home responses.
        K_PEER_INVALID_RESPONSE,
        K_PEER_SHARED_RESPONSE,
        K_PEER_CONFLICT_RESPONSE,
        K_FORWARD_UNCHANGED_RESPONSE,
        K_FORWARD_INVALID_RESPONSE,
        K_FORWARD_SHARED_RESPONSE,
        K_FORWARD_INVALID_WRITEBACK_RESPONSE,
        K_FORWARD_SHARED_WRITEBACK_RESPONSE,
        K_PEER_INVALID_WRITEBACK_RESPONSE,
        K_PEER_SHARED_WRITEBACK_RESPONSE,

        // Non-data responses.
        K_COMPLETION_GRANT_EXCLUSIVE,
        K_GRANT_EXCLUSIVE_FORCE_ACK,
        K_COMPLETION_WITH_DATA,
        K_PLAIN_COMPLETION,
        K_COMPLETION_FORWARD_CODE,
        K_COMPLETION_FORWARD_INVALIDATE_OWN,
        K_COMPLETION_INVALIDATE_TO_EXCLUSIVE,

        // Snoops.
        K_SNOOP_CURRENT,
        K_SNOOP_CODE,
        K_SNOOP_DATA,
        K_SNOOP_INVALIDATE_OWN,
        K_SNOOP_INVALIDATE_TO_EXCLUSIVE,
        K_SNOOP_PREFETCH_HINT,

        // Noncoherent standard channel.
        K_MMIO_READ,
        K_INTERRUPT_ACKNOWLEDGE,
        K_FLOAT_ERROR_NOTICE,
        K_MMIO_PARTIAL_READ,
        K_CONFIGURATION_READ,
        K_LEGACY_IO_READ,
        K_CONFIGURATION_WRITE,
        K_LEGACY_IO_WRITE,
        K_STANDARD_CHANNEL_MESSAGE,

        // Noncoherent bypass channel.
        K_MMIO_WRITE,
        K_WRITE_COMBINABLE_WRITE,
        K_BYPASS_CHANNEL_MESSAGE,
        K_LOGICAL_MODE_INTERRUPT,
        K_PHYSICAL_MODE_INTERRUPT,
        K_INTERRUPT_PRIORITY_UPDATE,
        K_MMIO_PARTIAL_WRITE,
        K_WRITE_COMBINABLE_PARTIAL_WRITE,
        K_BYPASS_PEER_TRANSFER,

        // Data responses.
        K_COHERENT_DATA_RESPONSE,
        K_COHERENT_DATA_FORCE_ACK,
        K_COHERENT_DATA_COMPLETION,
        K_NONCOHERENT_DATA,
        K_WRITEBACK_DATA_TO_INVALID,
        K_WRITEBACK_DATA_TO_SHARED,
        K_WRITEBACK_DATA_TO_EXCLUSIVE,
        K_UNCACHED_WRITE_DATA,
        K_PARTIAL_WRITEBACK_TO_INVALID,
        K_PARTIAL_WRITEBACK_TO_EXCLUSIVE,
        K_PARTIAL_UNCACHED_WRITE_DATA
    } clpm_kind_t;

    // ========================================================================
    // Header decode
    // ========================================================================
    // Class and opcode are decoded as one pair, so an opcode that is legal in
    // one class cannot leak into another. A full table costs a little more
    // logic than a mask but makes every accepted encoding visible by name.
    clpm_kind_t kind;

    always_comb begin
        kind = K_NONE;
        case (HDR_CLASS)
            // Reads, ownership, writebacks and conflict acknowledges. The
            // uncached reads and writes and the flush and eviction codes are
            // never produced by this device and stay without a kind.
            MC_HOME_REQ: begin
                case (HDR_OPCODE)
                    OP_RQ_READ_CURRENT:  kind = K_READ_CURRENT_SNAPSHOT;
                    OP_RQ_READ_CODE:     kind = K_READ_CODE_LINE;
                    OP_RQ_READ_DATA:     kind = K_READ_DATA_LINE;
                    OP_RQ_READ_INV_OWN:  kind = K_READ_INVALIDATE_OWN;
                    OP_RQ_INV_TO_EXCL:   kind = K_INVALIDATE_TO_EXCLUSIVE;
                    OP_RQ_ACK_WITH_WB:   kind = K_CONFLICT_ACK_WITH_WRITEBACK;
                    OP_RQ_WB_TO_INVALID: kind = K_MODIFIED_WRITEBACK_TO_INVALID;
                    OP_RQ_WB_TO_EXCL:    kind = K_MODIFIED_WRITEBACK_TO_EXCLUSIVE;
                    OP_RQ_WB_TO_SHARED:  kind = K_MODIFIED_WRITEBACK_TO_SHARED;
                    OP_RQ_CONFLICT_ACK:  kind = K_CONFLICT_ACKNOWLEDGE;
                    default:             kind = K_NONE;
                endcase
            end

            // Snoop responses from peers. The buried-owner conflict forms
            // are never produced here.
            MC_HOME_RSP: begin
                case (HDR_OPCODE)
                    OP_RS_PEER_INVALID:    kind = K_PEER_INVALID_RESPONSE;
                    OP_RS_PEER_SHARED:     kind = K_PEER_SHARED_RESPONSE;
                    OP_RS_PEER_CONFLICT:   kind = K_PEER_CONFLICT_RESPONSE;
                    OP_RS_FWD_UNCHANGED:   kind = K_FORWARD_UNCHANGED_RESPONSE;
                    OP_RS_FWD_INVALID:     kind = K_FORWARD_INVALID_RESPONSE;
                    OP_RS_FWD_SHARED:      kind = K_FORWARD_SHARED_RESPONSE;
                    OP_RS_FWD_INVALID_WB:  kind = K_FORWARD_INVALID_WRITEBACK_RESPONSE;
                    OP_RS_FWD_SHARED_WB:   kind = K_FORWARD_SHARED_WRITEBACK_RESPONSE;
                    OP_RS_PEER_INVALID_WB: kind = K_PEER_INVALID_WRITEBACK_RESPONSE;
                    OP_RS_PEER_SHARED_WB:  kind = K_PEER_SHARED_WRITEBACK_RESPONSE;
                    default:               kind = K_NONE;
                endcase
            end

            // Grants and completions. The time-out abort and the forced
            // acknowledge without grant are never produced here.
            MC_NONDATA: begin
                case (HDR_OPCODE)
                    OP_ND_GRANT_EXCL:      kind = K_COMPLETION_GRANT_EXCLUSIVE;
                    OP_ND_GRANT_FORCE_ACK: kind = K_GRANT_EXCLUSIVE_FORCE_ACK;
                    OP_ND_CMP_WITH_DATA:   kind = K_COMPLETION_WITH_DATA;
                    OP_ND_CMP_PLAIN:       kind = K_PLAIN_COMPLETION;
                    OP_ND_CMP_FWD_CODE:    kind = K_COMPLETION_FORWARD_CODE;
                    OP_ND_CMP_FWD_INV_OWN: kind = K_COMPLETION_FORWARD_INVALIDATE_OWN;
                    OP_ND_CMP_INV_TO_EXCL: kind = K_COMPLETION_INVALIDATE_TO_EXCLUSIVE;
                    default:               kind = K_NONE;
                endcase
            end

            // Outgoing snoops. The flush snoop and the migratory snoop are
            // never produced here.
            MC_SNOOP: begin
                case (HDR_OPCODE)
                    OP_SN_CURRENT:       kind = K_SNOOP_CURRENT;
                    OP_SN_CODE:          kind = K_SNOOP_CODE;
                    OP_SN_DATA:          kind = K_SNOOP_DATA;
                    OP_SN_INV_OWN:       kind = K_SNOOP_INVALIDATE_OWN;
                    OP_SN_INV_TO_EXCL:   kind = K_SNOOP_INVALIDATE_TO_EXCLUSIVE;
                    OP_SN_PREFETCH_HINT: kind = K_SNOOP_PREFETCH_HINT;
                    default:             kind = K_NONE;
                endcase
            end

            // Ordered noncoherent traffic. The peer-to-peer standard form is
            // never produced here.
            MC_NC_STD: begin
                case (HDR_OPCODE)
                    OP_NS_MMIO_READ:      kind = K_MMIO_READ;
                    OP_NS_INT_ACK:        kind = K_INTERRUPT_ACKNOWLEDGE;
                    OP_NS_FLOAT_ERROR:    kind = K_FLOAT_ERROR_NOTICE;
                    OP_NS_MMIO_PART_READ: kind = K_MMIO_PARTIAL_READ;
                    OP_NS_CFG_READ:       kind = K_CONFIGURATION_READ;
                    OP_NS_IO_READ:        kind = K_LEGACY_IO_READ;
                    OP_NS_CFG_WRITE:      kind = K_CONFIGURATION_WRITE;
                    OP_NS_IO_WRITE:       kind = K_LEGACY_IO_WRITE;
                    OP_NS_MESSAGE:        kind = K_STANDARD_CHANNEL_MESSAGE;
                    default:              kind = K_NONE;
                endcase
            end

            // Bypass noncoherent traffic. The debug data code is never
            // produced here.
            MC_NC_BYPASS: begin
                case (HDR_OPCODE)
                    OP_NB_MMIO_WRITE:      kind = K_MMIO_WRITE;
                    OP_NB_WC_WRITE:        kind = K_WRITE_COMBINABLE_WRITE;
                    OP_NB_MESSAGE:         kind = K_BYPASS_CHANNEL_MESSAGE;
                    OP_NB_INT_LOGICAL:     kind = K_LOGICAL_MODE_INTERRUPT;
                    OP_NB_INT_PHYSICAL:    kind = K_PHYSICAL_MODE_INTERRUPT;
                    OP_NB_INT_PRIO_UPDATE: kind = K_INTERRUPT_PRIORITY_UPDATE;
                    OP_NB_MMIO_PART_WRITE: kind = K_MMIO_PARTIAL_WRITE;
                    OP_NB_WC_PART_WRITE:   kind = K_WRITE_COMBINABLE_PARTIAL_WRITE;
                    OP_NB_PEER_TRANSFER:   kind = K_BYPASS_PEER_TRANSFER;
                    default:               kind = K_NONE;
                endcase
            end

            // Data carrying responses and writebacks. The first three forms
            // also carry a cache state, qualified below. Opcode 1001 stays
            // unused, so it never matches.
            MC_DATA_RSP: begin
                case (HDR_OPCODE)
                    OP_DATA_COHERENT:      kind = K_COHERENT_DATA_RESPONSE;
                    OP_DATA_FRC_ACK:       kind = K_COHERENT_DATA_FORCE_ACK;
                    OP_DATA_CMP:           kind = K_COHERENT_DATA_COMPLETION;
                    OP_DR_NONCOHERENT:     kind = K_NONCOHERENT_DATA;
                    OP_DR_WB_TO_INVALID:   kind = K_WRITEBACK_DATA_TO_INVALID;
                    OP_DR_WB_TO_SHARED:    kind = K_WRITEBACK_DATA_TO_SHARED;
                    OP_DR_WB_TO_EXCL:      kind = K_WRITEBACK_DATA_TO_EXCLUSIVE;
                    OP_DR_UNCACHED_WRITE:  kind = K_UNCACHED_WRITE_DATA;
                    OP_DR_PART_WB_INVALID: kind = K_PARTIAL_WRITEBACK_TO_INVALID;
                    OP_DR_PART_WB_EXCL:    kind = K_PARTIAL_WRITEBACK_TO_EXCLUSIVE;
                    OP_DR_PART_UNCACHED:   kind = K_PARTIAL_UNCACHED_WRITE_DATA;
                    default:               kind = K_NONE;
                endcase
            end

            default: kind = K_NONE;
        endcase
    end

    // ========================================================================
    // Cache state qualification
    // ========================================================================
    // Only the three coherent data response forms carry a cache state. The
    // plain form can report M as well; the completion and forced-acknowledge
    // forms cannot, so selecting M or S for them counts nothing.
    logic state_ok;

    always_comb begin
        state_ok = 1'b1;
        case (kind)
            K_COHERENT_DATA_RESPONSE: begin
                case (HDR_CACHE_STATE)
                    CS_STATE_E, CS_STATE_F,
                    CS_STATE_I, CS_STATE_M: state_ok = 1'b1;
                    default:                state_ok = 1'b0;
                endcase
            end
            K_COHERENT_DATA_FORCE_ACK,
            K_COHERENT_DATA_COMPLETION: begin
                case (HDR_CACHE_STATE)
                    CS_STATE_E, CS_STATE_F, CS_STATE_I: state_ok = 1'b1;
                    default:                            state_ok = 1'b0;
                endcase
            end
            default: state_ok = 1'b1;
        endcase
    end

    // ========================================================================
    // Match decision
    // ========================================================================
    // The programmed class and opcode must equal the header as a pair, and
    // the header must decode to a kind, so programming an encoding that this
    // device never produces leaves the counter idle.
    logic stateful;
    logic hit;
    logic assigned;
    logic match_d,    match_q;
    logic assigned_d, assigned_q;

    always_comb begin
        assigned = (kind != K_NONE);
        stateful = (kind == K_COHERENT_DATA_RESPONSE)
                 || (kind == K_COHERENT_DATA_FORCE_ACK)
                 || (kind == K_COHERENT_DATA_COMPLETION);
        hit = MATCH_ENABLE && assigned
            && (HDR_CLASS == MATCH_CLASS) && (HDR_OPCODE == MATCH_OPCODE);
        if (stateful) begin
            hit = hit && (HDR_CACHE_STATE == CACHE_STATE_SELECT)
                && state_ok;
        end
        match_d    = HDR_VALID && hit;
        assigned_d = HDR_VALID && assigned;
    end

    // Both outputs are held low between headers so the counter sees a pulse.
    // While the clock enable is low both flops keep their value, so the
    // counter must be frozen by the same enable or it counts a pulse twice.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            match_q    <= RST_MATCH;
            assigned_q <= RST_MATCH;
        end else if (CLK_EN) begin
            match_q    <= match_d;
            assigned_q <= assigned_d;
        end
    end

    assign MATCH_PULSE  = match_q;
    assign HDR_ASSIGNED = assigned_q;

endmodule

// ==== verif/clpm_matcher_sva.sv ====
// Port checker for the packet matcher.
`timescale 1ns/1ps
module clpm_matcher_sva (
    // Clock, control and outputs
    input wire logic CLK_SYS, RST, CLK_EN, HDR_VALID, MATCH_ENABLE, MATCH_PULSE, HDR_ASSIGNED,
    // Header and programmed fields
    input wire logic [clpm_pkg::CLASS_W-1:0] HDR_CLASS, MATCH_CLASS,
    input wire logic [clpm_pkg::OPC_W-1:0] HDR_OPCODE, MATCH_OPCODE,
    input wire logic [clpm_pkg::STATE_W-1:0] HDR_CACHE_STATE, CACHE_STATE_SELECT
);
    import clpm_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_hdr; CLK_EN && HDR_VALID; endsequence
    property p_idle; CLK_EN && !HDR_VALID |=> !MATCH_PULSE && !HDR_ASSIGNED; endproperty
    a_idle: assert property (p_idle) else $error("output with no header");
    property p_sub; MATCH_PULSE |-> HDR_ASSIGNED; endproperty
    a_sub: assert property (p_sub) else $error("match on unassigned code");
    property p_off; CLK_EN && !MATCH_ENABLE |=> !MATCH_PULSE; endproperty
    a_off: assert property (p_off) else $error("match while disabled");
    property p_cls; s_hdr ##0 HDR_CLASS != MATCH_CLASS |=> !MATCH_PULSE; endproperty
    a_cls: assert property (p_cls) else $error("match on other class");
    property p_una; s_hdr ##0 HDR_CLASS inside {[4'h5:4'hb], 4'hd, 4'hf} |=> !HDR_ASSIGNED; endproperty
    a_una: assert property (p_una) else $error("unassigned class taken");
    property p_frz; !CLK_EN |=> $stable(MATCH_PULSE) && $stable(HDR_ASSIGNED); endproperty
    a_frz: assert property (p_frz) else $error("output moved while frozen");
    property p_hit; s_hdr ##0 MATCH_ENABLE
        && {HDR_CLASS, HDR_OPCODE, MATCH_CLASS, MATCH_OPCODE} == 16'h0 |=> MATCH_PULSE; endproperty
    a_hit: assert property (p_hit) else $error("home read missed");
    property p_st; s_hdr ##0 HDR_CLASS == MC_DATA_RSP && HDR_OPCODE == OP_DATA_COHERENT
        && HDR_CACHE_STATE != CACHE_STATE_SELECT |=> !MATCH_PULSE; endproperty
    a_st: assert property (p_st) else $error("wrong cache state matched");
endmodule
bind clpm_matcher clpm_matcher_sva clpm_matcher_sva_inst (.*);

// ==== verif/clpm_count_model.sv ====
// Monitoring counter model that tallies match pulses.
`timescale 1ns/1ps
module clpm_count_model (
    // Clock, reset and pulse
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pulse,
    // Running tally
    output logic [15:0] count
);
    // One count per pulse cycle, so a stretched pulse shows up as extra counts.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) count <= 16'h0;
        else count <= count + {15'h0, pulse};
    end
endmodule

// ==== verif/test_clpm_matcher.sv ====
// Self-checking bench for the packet matcher.
`timescale 1ns/1ps
module test_clpm_matcher;
    import clpm_pkg::*;
    logic CLK_SYS, RST, CLK_EN, HDR_VALID, MATCH_ENABLE, MATCH_PULSE, HDR_ASSIGNED;
    logic [3:0] HDR_CLASS, MATCH_CLASS, HDR_OPCODE, MATCH_OPCODE;
    logic [2:0] HDR_CACHE_STATE, CACHE_STATE_SELECT;
    logic [15:0] tally, n_hits;
    int n_errors = 0, checks_done = 0;
    clpm_matcher clpm_matcher_inst (.*);
    clpm_count_model clpm_count_model_inst (.clk_sys(CLK_SYS), .rst(RST), .pulse(MATCH_PULSE),
        .count(tally));
    initial begin
        CLK_SYS = 0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end
    task automatic check(input logic [15:0] seen, want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Opcodes each class assigns.
    // Bit n set means opcode n is counted.
    // Holes stay clear.
    function automatic logic known(input logic [3:0] c, o);
        logic [15:0] m;
        m = c == 4'h0 ? 16'hf317 : c == 4'h1 ? 16'h7f13 : c == 4'h2 ? 16'h1d13 : c == 4'h3 ?
            16'h8117 : c == 4'h4 ? 16'h1abb : c == 4'hc ? 16'h7f03 : c == 4'he ? 16'h0dff : 16'h0;
        return m[o];
    endfunction
    task automatic hdr(input logic [3:0] c, o, mc, input logic [2:0] s, sel, input logic en);
        logic ok;
        ok = known(c, o) && en && mc == c;
        if (c == MC_DATA_RSP && o <= OP_DATA_CMP)
            ok = ok && s == sel && (s inside {CS_STATE_E, CS_STATE_F, CS_STATE_I}
                 || o == OP_DATA_COHERENT && s == CS_STATE_M);
        {HDR_VALID, HDR_CLASS, HDR_OPCODE, HDR_CACHE_STATE} = {1'b1, c, o, s};
        {MATCH_ENABLE, MATCH_CLASS, MATCH_OPCODE, CACHE_STATE_SELECT} = {en, mc, o, sel};
        @(negedge CLK_SYS);
        if (ok) n_hits++;
        check(HDR_ASSIGNED, known(c, o));
        check(MATCH_PULSE, ok);
    endtask
    task automatic sweep_codes();
        for (int i = 0; i < 256; i++) begin
            hdr(4'(i / 16), 4'(i), 4'(i / 16), CS_STATE_F, CS_STATE_F, 1);
        end
        for (int i = 0; i < 75; i++) begin
            hdr(MC_DATA_RSP, 4'(i / 25), MC_DATA_RSP, 3'(i / 5 % 5), 3'(i % 5), 1);
        end
        HDR_VALID = 0;
        @(negedge CLK_SYS);
        check(tally, n_hits);
    endtask
    task automatic odd_cases();
        {HDR_VALID, HDR_CLASS, HDR_OPCODE, MATCH_ENABLE} = {1'b1, MC_HOME_REQ, 4'h1, 1'b1};
        {MATCH_CLASS, MATCH_OPCODE} = {MC_HOME_REQ, 4'h0};
        @(negedge CLK_SYS);
        check(MATCH_PULSE, 0);
        check(HDR_ASSIGNED, 1);
        hdr(MC_HOME_REQ, 4'h0, MC_HOME_RSP, CS_STATE_F, CS_STATE_F, 1);
        hdr(MC_HOME_REQ, 4'h0, MC_HOME_REQ, CS_STATE_F, CS_STATE_F, 0);
        hdr(MC_HOME_REQ, 4'h0, MC_HOME_REQ, CS_STATE_F, CS_STATE_F, 1);
        {CLK_EN, HDR_VALID} = 2'b00;
        @(negedge CLK_SYS);
        check(MATCH_PULSE, 1);
        CLK_EN = 1;
        @(negedge CLK_SYS);
        check(MATCH_PULSE, 0);
    endtask
    task automatic end_of_test();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {RST, CLK_EN, HDR_VALID, MATCH_ENABLE, HDR_CLASS, MATCH_CLASS} = 12'hc00;
        {HDR_OPCODE, MATCH_OPCODE, HDR_CACHE_STATE, CACHE_STATE_SELECT, n_hits} = '0;
        repeat (8) @(negedge CLK_SYS);
        RST = 0;
        sweep_codes();
        odd_cases();
        end_of_test();
    end
endmodule
